// ---- pkg/sra_pkg.sv ----
package sra_pkg;
  // timing clock
  localparam int CLK_HZ = 100_000_000;
  localparam int TIMING_HZ = 32_000;
  localparam int TICK_CYCLES = CLK_HZ / TIMING_HZ;
  localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
  localparam int TICKS_PER_DIV = 4;

  // register offsets
  localparam logic [7:0] ADDR_SAMPLE_RATE_DIVIDER = 8'h12;
  localparam logic [7:0] ADDR_SAMPLE_AVERAGING_CONFIG = 8'h15;
  localparam logic [7:0] ADDR_SLOT_A_CH1_ADC_OFFSET = 8'h18;
  localparam logic [7:0] ADDR_SLOT_A_CH2_ADC_OFFSET = 8'h19;
  localparam logic [7:0] ADDR_FIFO_DATA = 8'h60;
  localparam logic [7:0] ADDR_AVG_FIRST = 8'h64;
  localparam logic [7:0] ADDR_AVG_LAST = 8'h6B;
  localparam logic [7:0] ADDR_SUM_FIRST = 8'h70;
  localparam logic [7:0] ADDR_SUM_LAST = 8'h7F;

  // reset values and fields
  localparam logic [15:0] RST_SAMPLE_RATE_DIVIDER = 16'h0028;
  localparam logic [2:0] RST_SECOND_SLOT_AVG = 3'h6;
  localparam logic [2:0] RST_FIRST_SLOT_AVG = 3'h0;
  localparam logic [15:0] RST_ADC_OFFSET = 16'h2000;
  localparam int SECOND_SLOT_AVG_LSB = 8;
  localparam int FIRST_SLOT_AVG_LSB = 4;
  localparam logic [15:0] AVG_CFG_MASK = 16'h0770;
  localparam logic [1:0] SYNC_INTERNAL = 2'h0;

  // datapath sizes
  localparam int SUM_W = 23;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] LAST_CH = 2'h3;

  typedef enum logic [0:0] {
    ST_ACCUM = 1'b0,
    ST_PUSH = 1'b1
  } phase_type;

  typedef struct packed {
    logic valid;
    logic slot;
    logic [1:0] chan;
    logic [15:0] data;
  } adc_sample_type;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic [11:0] tick_cnt;
    logic [17:0] samp_cnt;
    logic strobe;
    logic [15:0] divider;
    logic [15:0] avg_cfg;
    logic [1:0][15:0] offset;
    logic [7:0][SUM_W-1:0] sum;
    logic [1:0][7:0] grp_cnt;
    logic [7:0][15:0] avg16;
    logic [7:0][31:0] wide;
    phase_type phase;
    logic push_slot;
    logic [1:0] push_ch;
    logic [15:0] rdata;
  } core_state_type;
endpackage

// ---- core/sample_rate_average_offset.sv ----
`timescale 1ns/1ps

// small fifo between the averager and the register read port
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] wr_ptr_nxt;
  logic [AW:0] rd_ptr_r;
  logic [AW:0] rd_ptr_nxt;
  logic full;
  logic empty;

  // extra pointer bit tells full from empty
  assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem[rd_ptr_r[AW-1:0]];

  // pointer advance
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    if (in_valid_in && !full) begin
      wr_ptr_nxt = wr_ptr_r + 1'b1;
    end
    if (out_ready_in && !empty) begin
      rd_ptr_nxt = rd_ptr_r + 1'b1;
    end
    if (!resetn_in) begin
      wr_ptr_nxt = '0;
      rd_ptr_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    wr_ptr_r <= wr_ptr_nxt;
    rd_ptr_r <= rd_ptr_nxt;
    if (in_valid_in && !full) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data_in;
    end
  end
endmodule

// Overview of operation
// (RQ1) The sample rate is the 32 kHz timing rate divided by four times the divider register value.
// (RQ2) Bits [10:8] of the averaging config pick 1 to 128 summed samples for slot B and reset to 6.
// (RQ3) Each completed group's full sum of every slot and channel is readable at 0x70 to 0x7F.
// (RQ4) Each group's average lands at 0x64 to 0x6B and is also pushed into the fifo read at 0x60.
// (RQ5) The average is the sum divided by the sample count, held in 16-bit registers.
// (RQ6) One result leaves per completed group, so output rate is sample rate over the average count.
// (RQ7) Bits [6:4] pick the slot A count with the same mapping and reset to 0, one sample.
// (RQ8) A 16-bit per-channel offset, reset 0x2000, is subtracted from each raw value before summing; only slot A ch1/ch2 are writable, others use 0x2000.
// (RQ9) With trigger select 00 samples are timed from the internal 32 kHz rate and the divider.
// (RQ10) Software writes zeros to reserved config bits and does not trust what they read back.
module sample_rate_average_offset
  import sra_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire reg_req_type reg_req_in,
  output logic [15:0] reg_rdata_out,
  input wire logic [1:0] sample_trigger_select_in,
  output logic sample_strobe_out,
  input wire adc_sample_type adc_in,
  output logic adc_ready_out
);
  core_state_type s_r;
  core_state_type s_nxt;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [15:0] fifo_out_data;

  // averaging code of one slot, read only by the accumulator
  function automatic logic [2:0] avg_code(input logic [15:0] cfg, input logic slot);
    avg_code = slot ? cfg[SECOND_SLOT_AVG_LSB +: 3] : cfg[FIRST_SLOT_AVG_LSB +: 3];
  endfunction

  // adc is held off while a finished group drains into the fifo
  assign adc_ready_out = (s_r.phase == ST_ACCUM);
  assign fifo_in_valid = (s_r.phase == ST_PUSH);
  assign fifo_pop = reg_req_in.rd && (reg_req_in.addr == ADDR_FIFO_DATA) && fifo_out_valid;
  assign sample_strobe_out = s_r.strobe;
  assign reg_rdata_out = s_r.rdata;

  sample_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(s_r.avg16[{s_r.push_slot, s_r.push_ch}]), // RQ4
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_out_data)
  );

  // group length of an averaging code, 1 to 128 samples
  function automatic logic [7:0] group_size(input logic [2:0] code_in);
    group_size = 8'h01 << code_in; // RQ2 RQ7
  endfunction

  // offset for one slot and channel
  // channels without an offset register keep the reset offset, so their data stays centred
  function automatic logic [15:0] offset_for(
    input logic [1:0][15:0] regs,
    input logic slot,
    input logic [1:0] chan
  );
    if (!slot && (chan == 2'h0)) begin
      offset_for = regs[0]; // RQ8
    end else if (!slot && (chan == 2'h1)) begin
      offset_for = regs[1]; // RQ8
    end else begin
      offset_for = RST_ADC_OFFSET;
    end
  endfunction

  // one 16-bit half of a wide sum word
  // bit 3 of the offset picks the slot, bit 2 the high half, bits 1:0 the channel
  function automatic logic [15:0] sum_word(input logic [7:0][31:0] wide, input logic [3:0] off);
    logic [2:0] pick;
    pick = {off[3], off[1:0]};
    if (off[2]) begin
      sum_word = wide[pick][31:16]; // RQ3
    end else begin
      sum_word = wide[pick][15:0]; // RQ3
    end
  endfunction

  // all next-state logic of the block
  always_comb begin
    logic tick;
    logic [15:0] div_eff;
    logic [17:0] period;
    logic [15:0] ofs;
    logic [15:0] diff;
    logic [2:0] idx;
    logic [2:0] j;
    logic [2:0] code;
    logic [7:0] grp;
    logic [SUM_W-1:0] total;
    logic [7:0] roff;
    tick = 1'b0;
    div_eff = '0;
    period = '0;
    ofs = '0;
    diff = '0;
    idx = '0;
    j = '0;
    code = '0;
    grp = '0;
    total = '0;
    roff = '0;
    s_nxt = s_r;
    s_nxt.strobe = 1'b0;

    // 32 kHz timing tick from the fast clock
    tick = (s_r.tick_cnt == TICK_LAST);
    if (tick) begin
      s_nxt.tick_cnt = '0;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 12'h001;
    end

    // sample period is four ticks per divider count
    // a zero divider would never wrap, so it runs as one
    if (s_r.divider == 16'h0000) begin
      div_eff = 16'h0001;
    end else begin
      div_eff = s_r.divider;
    end
    period = {div_eff, 2'b00}; // RQ1
    // compare with >= so a smaller divider written mid-period takes effect at once
    if (tick) begin
      if (s_r.samp_cnt >= (period - 18'h00001)) begin
        s_nxt.samp_cnt = '0;
        s_nxt.strobe = (sample_trigger_select_in == SYNC_INTERNAL); // RQ9
      end else begin
        s_nxt.samp_cnt = s_r.samp_cnt + 18'h00001; // RQ1
      end
    end

    // register writes
    if (reg_req_in.wr) begin
      if (reg_req_in.addr == ADDR_SAMPLE_RATE_DIVIDER) begin
        s_nxt.divider = reg_req_in.wdata; // RQ1
      end else if (reg_req_in.addr == ADDR_SAMPLE_AVERAGING_CONFIG) begin
        s_nxt.avg_cfg = reg_req_in.wdata & AVG_CFG_MASK; // RQ2 RQ7
      end else if (reg_req_in.addr == ADDR_SLOT_A_CH1_ADC_OFFSET) begin
        s_nxt.offset[0] = reg_req_in.wdata; // RQ8
      end else if (reg_req_in.addr == ADDR_SLOT_A_CH2_ADC_OFFSET) begin
        s_nxt.offset[1] = reg_req_in.wdata; // RQ8
      end
    end

    // register reads, data stands from the edge after the request until the next read
    if (reg_req_in.rd) begin
      if (reg_req_in.addr == ADDR_SAMPLE_RATE_DIVIDER) begin
        s_nxt.rdata = s_r.divider;
      end else if (reg_req_in.addr == ADDR_SAMPLE_AVERAGING_CONFIG) begin
        s_nxt.rdata = s_r.avg_cfg;
      end else if (reg_req_in.addr == ADDR_SLOT_A_CH1_ADC_OFFSET) begin
        s_nxt.rdata = s_r.offset[0];
      end else if (reg_req_in.addr == ADDR_SLOT_A_CH2_ADC_OFFSET) begin
        s_nxt.rdata = s_r.offset[1];
      end else if (reg_req_in.addr == ADDR_FIFO_DATA) begin
        // empty fifo reads as zero rather than stale data
        if (fifo_out_valid) begin
          s_nxt.rdata = fifo_out_data; // RQ4
        end else begin
          s_nxt.rdata = 16'h0000;
        end
      end else if ((reg_req_in.addr >= ADDR_AVG_FIRST) && (reg_req_in.addr <= ADDR_AVG_LAST)) begin
        roff = reg_req_in.addr - ADDR_AVG_FIRST;
        s_nxt.rdata = s_r.avg16[roff[2:0]]; // RQ4
      end else if ((reg_req_in.addr >= ADDR_SUM_FIRST) && (reg_req_in.addr <= ADDR_SUM_LAST)) begin
        roff = reg_req_in.addr - ADDR_SUM_FIRST;
        s_nxt.rdata = sum_word(s_r.wide, roff[3:0]); // RQ3
      end else begin
        s_nxt.rdata = 16'h0000;
      end
    end

    // accumulate samples, then drain one finished group into the fifo
    case (s_r.phase)
      ST_ACCUM: begin
        if (adc_in.valid) begin
          ofs = offset_for(s_r.offset, adc_in.slot, adc_in.chan);
          // a raw value below its offset floors at zero instead of wrapping
          if (adc_in.data > ofs) begin
            diff = adc_in.data - ofs; // RQ8
          end else begin
            diff = 16'h0000;
          end
          idx = {adc_in.slot, adc_in.chan};
          code = avg_code(s_r.avg_cfg, adc_in.slot);
          grp = s_r.grp_cnt[adc_in.slot];
          s_nxt.sum[idx] = s_r.sum[idx] + SUM_W'(diff);
          // a group counts whole samples, so it ends on the last channel
          if (adc_in.chan == LAST_CH) begin
            // >= also ends a group when the count is lowered mid-group
            if (grp >= (group_size(code) - 8'h01)) begin
              for (int k = 0; k < 4; k++) begin
                j = {adc_in.slot, 2'(k)};
                if (2'(k) == adc_in.chan) begin
                  total = s_r.sum[j] + SUM_W'(diff);
                end else begin
                  total = s_r.sum[j];
                end
                s_nxt.wide[j] = 32'(total); // RQ3
                s_nxt.avg16[j] = 16'(total >> code); // RQ5
                s_nxt.sum[j] = '0;
              end
              s_nxt.grp_cnt[adc_in.slot] = 8'h00;
              s_nxt.phase = ST_PUSH; // RQ6
              s_nxt.push_slot = adc_in.slot;
              s_nxt.push_ch = 2'h0;
            end else begin
              s_nxt.grp_cnt[adc_in.slot] = grp + 8'h01;
            end
          end
        end
      end
      ST_PUSH: begin
        // a full fifo holds the adc off rather than losing a result
        if (fifo_in_ready) begin
          if (s_r.push_ch == LAST_CH) begin
            s_nxt.phase = ST_ACCUM; // RQ6
          end else begin
            s_nxt.push_ch = s_r.push_ch + 2'h1; // RQ4
          end
        end
      end
      default: begin
        s_nxt.phase = ST_ACCUM;
      end
    endcase

    // synchronous reset to the documented defaults
    if (!resetn_in) begin
      s_nxt = '0;
      s_nxt.divider = RST_SAMPLE_RATE_DIVIDER; // RQ1
      s_nxt.avg_cfg[SECOND_SLOT_AVG_LSB +: 3] = RST_SECOND_SLOT_AVG; // RQ2
      s_nxt.avg_cfg[FIRST_SLOT_AVG_LSB +: 3] = RST_FIRST_SLOT_AVG; // RQ7
      s_nxt.offset[0] = RST_ADC_OFFSET; // RQ8
      s_nxt.offset[1] = RST_ADC_OFFSET; // RQ8
      s_nxt.phase = ST_ACCUM;
    end
  end

  // the whole state is one register
  always_ff @(posedge ref_clk_in) begin
    s_r <= s_nxt;
  end
endmodule

// ---- testbench/sra_chk.sv ----
`timescale 1ns/1ps
module sra_chk
  import sra_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire reg_req_type reg_req_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [1:0] sample_trigger_select_in,
  input wire logic sample_strobe_out,
  input wire adc_sample_type adc_in,
  input wire logic adc_ready_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  // the sample strobe is one cycle wide and thousands of cycles apart
  chk_tick_pulse: assert property (sample_strobe_out |=> !sample_strobe_out[*8]) else $error("tick");
  chk_ext_silent: assert property ($past(sample_trigger_select_in) != 2'h0 |-> !sample_strobe_out) else $error("ext");
  // a write followed by a read of the same place returns the written word
  chk_div_back: assert property (reg_req_in.wr && reg_req_in.addr == ADDR_SAMPLE_RATE_DIVIDER ##1
    reg_req_in.rd && reg_req_in.addr == ADDR_SAMPLE_RATE_DIVIDER
    |=> reg_rdata_out == $past(reg_req_in.wdata, 2)) else $error("div");
  chk_off1_back: assert property (reg_req_in.wr && reg_req_in.addr == ADDR_SLOT_A_CH1_ADC_OFFSET ##1
    reg_req_in.rd && reg_req_in.addr == ADDR_SLOT_A_CH1_ADC_OFFSET
    |=> reg_rdata_out == $past(reg_req_in.wdata, 2)) else $error("off");
  chk_off2_back: assert property (reg_req_in.wr && reg_req_in.addr == ADDR_SLOT_A_CH2_ADC_OFFSET ##1
    reg_req_in.rd && reg_req_in.addr == ADDR_SLOT_A_CH2_ADC_OFFSET
    |=> reg_rdata_out == $past(reg_req_in.wdata, 2)) else $error("off2");
  // reserved bits are masked off, only the count fields matter
  chk_cfg_back: assert property (reg_req_in.wr && reg_req_in.addr == 8'h15 ##1 reg_req_in.rd && reg_req_in.addr == 8'h15
    |=> (reg_rdata_out & 16'h0770) == ($past(reg_req_in.wdata, 2) & 16'h0770)) else $error("cfg");
endmodule
bind sample_rate_average_offset sra_chk sra_chk_inst (.*);

// ---- testbench/sample_rate_average_offset_test.sv ----
`timescale 1ns/1ps
module sample_rate_average_offset_test;
  import sra_pkg::*;
  logic ref_clk_in, resetn_in, sample_strobe_out, adc_ready_out;
  logic [1:0] sel;
  logic [15:0] rv, rdata, o, s0, s1;
  logic [7:0] a;
  int gap;
  reg_req_type req;
  adc_sample_type adc;
  int miscompares, total_checks;
  sample_rate_average_offset sample_rate_average_offset_inst (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .reg_req_in(req), .reg_rdata_out(rdata), .sample_trigger_select_in(sel), .sample_strobe_out(sample_strobe_out),
    .adc_in(adc), .adc_ready_out(adc_ready_out));
  initial begin
    ref_clk_in = 0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task chk(input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h want %h", $time, s, e);
    end
  endtask
  // request held one cycle, read data taken after the edge
  task acc(input logic [7:0] a, input logic w, r, input logic [15:0] d);
    req = '{a, w, r, d};
    @(posedge ref_clk_in) #1;
    rv = rdata;
  endtask
  task send(input logic [1:0] c, input logic [15:0] d);
    adc = '{1'b1, 1'b0, c, d};
    for (int k = 0; k < 50 && !adc_ready_out; k++) @(posedge ref_clk_in) #1;
    @(posedge ref_clk_in) #1;
  endtask
  // two-sample group, offset removed before summing
  function automatic logic [15:0] sum2(input logic [15:0] a, b, f);
    return a + b - 16'(2 * f);
  endfunction
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400_000;
    miscompares++;
    conclude;
  end
  initial begin
    resetn_in = 0;
    req = '0;
    sel = 0;
    adc = '0;
    void'($urandom(32'hae1dce61));
    repeat (10) @(posedge ref_clk_in);
    #1 resetn_in = 1;
    acc(8'h12, 0, 1, 0);
    chk(rv, 16'h0028);
    acc(8'h15, 0, 1, 0);
    chk(rv & AVG_CFG_MASK, 16'h0600);
    acc(8'h18, 0, 1, 0);
    chk(rv, 16'h2000);
    acc(8'h19, 0, 1, 0);
    chk(rv, 16'h2000);
    for (int i = 0; i < 9; i++) begin
      o = 16'($urandom) | 16'h0001;
      a = (i % 3 == 0) ? ADDR_SAMPLE_RATE_DIVIDER : (i % 3 == 1) ? ADDR_SLOT_A_CH1_ADC_OFFSET : ADDR_SLOT_A_CH2_ADC_OFFSET;
      acc(a, 1, 0, o);
      acc(a, 0, 1, 0);
      chk(rv, o);
    end
    acc(8'h15, 1, 0, 16'h0710);
    acc(8'h15, 0, 1, 0);
    chk(rv & AVG_CFG_MASK, 16'h0710);
    $display("test registers done");
    o = 16'h1000 + 16'($urandom % 4096);
    acc(8'h12, 1, 0, 16'h0001);
    acc(8'h18, 1, 0, o);
    acc(8'h00, 0, 0, 0);
    sel = 2'h1;
    repeat (4) @(posedge ref_clk_in) #1;
    sel = 2'h0;
    s0 = o + 16'($urandom % 4096);
    s1 = o + 16'($urandom % 4096);
    for (int n = 0; n < 2; n++)
      for (int c = 0; c < 4; c++) send(2'(c), c ? 16'h4000 : (n ? s1 : s0));
    chk(16'(adc_ready_out), 16'h0000);
    adc.valid = 0;
    for (int k = 0; k < 30000 && !sample_strobe_out; k++) @(posedge ref_clk_in) #1;
    chk(16'(sample_strobe_out), 16'h0001);
    gap = 0;
    do begin
      @(posedge ref_clk_in) #1;
      gap++;
    end while (!sample_strobe_out && gap < 20000);
    chk(16'(gap), 16'(4 * TICK_CYCLES));
    repeat (20) @(posedge ref_clk_in) #1;
    acc(8'h64, 0, 1, 0);
    chk(rv, sum2(s0, s1, o) >> 1);
    acc(8'h70, 0, 1, 0);
    chk(rv, sum2(s0, s1, o));
    acc(8'h60, 0, 1, 0);
    chk(rv, sum2(s0, s1, o) >> 1);
    acc(8'h00, 0, 0, 0);
    $display("test averaging done");
    conclude;
  end
endmodule
